// ---- core/poe_seq_pkg.sv ----
// Purpose: Shared constants for the four-port power sourcing sequencer
// Assumes: 10 MHz core clock, 8-bit register port
// Notes:   Long waits are top-level parameters so simulation can shorten them
//
// Overview of operation
// - Undervoltage, enable low or zero write resets
// - Reset restores defaults and latches strap pins
// - Input over-voltage shuts ports, then fresh detection
// - Two probe phases with pass transistor off
// - Detect-done flag, interrupt, valid goes to classification
// - Open, short, capacitance end early; low-impedance immediately
// - Other invalid signatures complete both phases
// - Invalid detection waits reset time, midspan longer
// - Midspan from strap or bits; valid detection clears
// - Over-limit current is high class or failure
// - High class off unless strap or port bit
// - Class done sets flag, interrupt, stores result
// - Class 0-3 once; class 4-5 dual if enabled
// - Second class result must match the first
// - Mark events between and after dual classification
// - Classification off once valid and powered
// - Ramp power, then set enabled and change flags
// - Output under two volts sets good flags
// - Valid detection unstarted after limit redetects
// - One port at a time, ports one to four
// - Next port detects after discharge interval
// - Unpowered ports keep rotating; shut ports rejoin
package poe_seq_pkg;

	// Clock and timing
	localparam int unsigned CLK_HZ         = 10_000_000;
	localparam int unsigned RESET_TIME_MS  = 80;
	localparam int unsigned MIDSPAN_MS     = 2800;
	localparam int unsigned START_LIMIT_MS = 400;
	localparam int unsigned PHASE_TIME_US  = 100;
	localparam int unsigned MARK_TIME_US   = 50;
	localparam int unsigned PHASE_CYC      = PHASE_TIME_US * (CLK_HZ / 1_000_000);
	localparam int unsigned MARK_CYC       = MARK_TIME_US * (CLK_HZ / 1_000_000);

	// Register offsets
	localparam logic [3:0] OFS_CTRL   = 4'h0;
	localparam logic [3:0] OFS_MID    = 4'h1;
	localparam logic [3:0] OFS_CLSCFG = 4'h2;
	localparam logic [3:0] OFS_EVENT  = 4'h3;
	localparam logic [3:0] OFS_PWR    = 4'h4;
	localparam logic [3:0] OFS_PWRCHG = 4'h5;
	localparam logic [3:0] OFS_RES0   = 4'h6;
	localparam logic [3:0] OFS_STRAP  = 4'hA;
	localparam logic [3:0] OFS_STATE  = 4'hB;

	// Reset values
	localparam logic [7:0] RST_BYTE   = 8'h00;

	// Detection result codes
	localparam logic [2:0] DET_NONE  = 3'h0;
	localparam logic [2:0] DET_SHORT = 3'h1;
	localparam logic [2:0] DET_CAP   = 3'h2;
	localparam logic [2:0] DET_LOWZ  = 3'h3;
	localparam logic [2:0] DET_VALID = 3'h4;
	localparam logic [2:0] DET_OPEN  = 3'h5;
	localparam logic [2:0] DET_BAD   = 3'h6;

	// Class codes
	localparam logic [2:0] CLS_FOUR  = 3'h4;
	localparam logic [2:0] CLS_HIGH  = 3'h5;
	localparam logic [2:0] CLS_FAIL  = 3'h7;

	// Sequencer states
	typedef enum logic [3:0] {
		S_START, S_GAP, S_DET1, S_DET2, S_CLS1, S_MARK1, S_CLS2, S_MARK2, S_RAMP, S_OVP
	} seq_state_t;

endpackage

// ---- core/poe_port_sequencer.sv ----
// Purpose: Detection, classification and start-up sequencer for four ports
// Assumes: Analog front end reports probe and class results as levels and pulses
// Notes:   One port is serviced at a time; powered ports drop out of the rotation
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module poe_port_sequencer
	import poe_seq_pkg::*;
#(
	parameter int unsigned RESET_CYC = RESET_TIME_MS * (CLK_HZ / 1000),
	parameter int unsigned MID_CYC   = MIDSPAN_MS * (CLK_HZ / 1000),
	parameter int unsigned START_CYC = START_LIMIT_MS * (CLK_HZ / 1000)
)
(
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       rst_n_i,
	// Register port
	input  wire logic [3:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	// Supply and enable
	input  wire logic       vin_uvlo_i,
	input  wire logic       vcc_uvlo_i,
	input  wire logic       en_i,
	input  wire logic       vin_ovp_i,
	// Straps
	input  wire logic       auto_strap_i,
	input  wire logic       midspan_strap_i,
	input  wire logic       high_power_class_strap_i,
	input  wire logic       power_budget_strap_i,
	input  wire logic [3:0] bus_id_straps_i,
	// Detection front end
	input  wire logic       det_open_i,
	input  wire logic       det_short_i,
	input  wire logic       det_cap_i,
	input  wire logic       det_lowz_i,
	input  wire logic       det_good_i,
	// Classification front end
	input  wire logic       class_done_i,
	input  wire logic [2:0] class_code_i,
	input  wire logic       class_over_i,
	// Power path
	input  wire logic [3:0] ramp_done_i,
	input  wire logic [3:0] out_below_2v_i,
	input  wire logic [3:0] port_off_i,
	// Drive outputs
	output logic      [1:0] port_sel_o,
	output logic            probe_en_o,
	output logic            probe_high_o,
	output logic            class_en_o,
	output logic            mark_en_o,
	output logic      [3:0] gate_o,
	output logic            irq_o
);

	// ********************************
	// Declarations
	// ********************************
	seq_state_t  state_q;          // Sequencer state
	logic [31:0] cnt_q;            // State timer
	logic [31:0] gap_q;            // Idle length before next port
	logic [31:0] wd_q;             // Start-up watchdog
	logic [1:0]  port_q;           // Port being serviced
	logic [2:0]  cls1_q;           // First class result
	logic        strap_load_q;     // Strap capture pending
	logic        auto_q;           // Latched straps
	logic        mid_strap_q;
	logic        hpc_strap_q;
	logic        pbud_q;
	logic [3:0]  bus_id_q;
	logic [3:0]  mid_q;            // Deferred detect bits
	logic [3:0]  hpc_en_q;         // High power class per port
	logic [3:0]  dual_en_q;        // Dual event per port
	logic [3:0]  det_done_q;       // Detect done flags
	logic [3:0]  cls_done_q;       // Class done flags
	logic [3:0]  pen_q;            // Power enabled
	logic [3:0]  pec_q;            // Power enable change
	logic [3:0]  pg_q;             // Power good
	logic [3:0]  pgc_q;            // Power good change
	logic [2:0]  det_res_q [4];    // Detection result per port
	logic [2:0]  cls_res_q [4];    // Class result per port
	logic [7:0]  rd_mux;           // Read data before register
	logic        clr;              // Synchronous full reset
	logic        phase_end;        // Probe phase over
	logic        det_finish;       // Detection cycle ends
	logic [2:0]  det_code;         // Detection verdict
	logic        hp_en;            // High class allowed here
	logic [2:0]  cls_now;          // Class of current event
	logic        cls_fin;          // Classification complete
	logic        cls_ok;           // Completed and valid
	logic [3:0]  sel;              // One-hot current port
	logic [3:0]  pen_set;
	logic [3:0]  pen_clr;
	logic [1:0]  nxt_port;
	logic [3:0]  pg_d;             // Next power good

	// Next unpowered port after cur, cur itself last
	function automatic logic [1:0] pick_next(input logic [1:0] cur, input logic [3:0] pw);
		logic [1:0] c;
		logic [1:0] r;
		r = cur;
		for (int i = 4; i >= 1; i--)
		begin
			c = cur + i[1:0];
			if (!pw[c])
				r = c;
		end
		return r;
	endfunction

	// ********************************
	// Event decode
	// ********************************
	// Reset sources
	assign clr = vin_uvlo_i | vcc_uvlo_i | ~en_i | (wr_i && addr_i == OFS_CTRL && !wdata_i[0]);
	assign sel = 4'h1 << port_q;
	assign phase_end = cnt_q >= PHASE_CYC - 1;
	assign hp_en = hpc_strap_q | hpc_en_q[port_q];
	assign nxt_port = pick_next(port_q, pen_q);

	always_comb
	begin
		det_finish = 1'b0;
		det_code   = DET_NONE;
		if ((state_q == S_DET1 || state_q == S_DET2) && det_lowz_i)
		begin
			det_finish = 1'b1;
			det_code   = DET_LOWZ;
		end
		else if (state_q == S_DET1 && (det_short_i | det_cap_i | det_open_i))
		begin
			det_finish = 1'b1;
			det_code   = det_short_i ? DET_SHORT : (det_cap_i ? DET_CAP : DET_OPEN);
		end
		else if (state_q == S_DET2 && phase_end)
		begin
			det_finish = 1'b1;
			det_code   = det_good_i ? DET_VALID : DET_BAD;
		end
	end

	// High class or failure on over-limit current
	always_comb
	begin
		if (class_over_i)
			cls_now = hp_en ? CLS_HIGH : CLS_FAIL;
		else
			cls_now = class_code_i;
	end

	always_comb
	begin
		cls_fin = 1'b0;
		cls_ok  = 1'b0;
		if (state_q == S_CLS1 && class_done_i)
		begin
			cls_fin = cls_now == CLS_FAIL || cls_now < CLS_FOUR || !dual_en_q[port_q];
			cls_ok  = cls_now != CLS_FAIL;
		end
		else if (state_q == S_CLS2 && class_done_i)
		begin
			cls_fin = 1'b1;
			cls_ok  = cls_now == cls1_q;
		end
	end

	// ********************************
	// Strap capture
	// ********************************
	// Latch once after each reset
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			strap_load_q <= 1'b1;
		else if (clr)
			strap_load_q <= 1'b1;
		else
			strap_load_q <= 1'b0;
	end

	// Strap values, held until the next reset
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			auto_q      <= 1'b0;
			mid_strap_q <= 1'b0;
			hpc_strap_q <= 1'b0;
			pbud_q      <= 1'b0;
			bus_id_q    <= 4'h0;
		end
		else if (strap_load_q && !clr)
		begin
			auto_q      <= auto_strap_i;
			mid_strap_q <= midspan_strap_i;
			hpc_strap_q <= high_power_class_strap_i;
			pbud_q      <= power_budget_strap_i;
			bus_id_q    <= bus_id_straps_i;
		end
	end

	// ********************************
	// Configuration registers
	// ********************************
	// Midspan bits from strap or software, cleared on valid detect
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			mid_q <= 4'h0;
		else if (clr)
			mid_q <= 4'h0;
		else if (strap_load_q)
			mid_q <= {4{midspan_strap_i}};
		else if (wr_i && addr_i == OFS_MID)
			mid_q <= wdata_i[3:0];
		else if (det_finish && det_code == DET_VALID)
			mid_q <= mid_q & ~sel;
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			hpc_en_q  <= 4'h0;
			dual_en_q <= 4'h0;
		end
		else if (clr)
		begin
			hpc_en_q  <= 4'h0;
			dual_en_q <= 4'h0;
		end
		else if (wr_i && addr_i == OFS_CLSCFG)
		begin
			hpc_en_q  <= wdata_i[3:0];
			dual_en_q <= wdata_i[7:4];
		end
	end

	// ********************************
	// Sequencer
	// ********************************
	// One port at a time in rotation
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_q <= S_START;
			cnt_q   <= 32'h0;
			gap_q   <= 32'h0;
			port_q  <= 2'h3;
			cls1_q  <= 3'h0;
		end
		else if (clr)
		begin
			state_q <= S_START;
			cnt_q   <= 32'h0;
			gap_q   <= 32'h0;
			port_q  <= 2'h3;
			cls1_q  <= 3'h0;
		end
		else if (vin_ovp_i)
		begin
			state_q <= S_OVP;
			cnt_q   <= 32'h0;
			port_q  <= 2'h3;
		end
		else
		begin
			cnt_q <= cnt_q + 32'h1;
			unique case (state_q)
				S_START, S_OVP:
				begin
					state_q <= S_GAP;
					gap_q   <= RESET_CYC;
					cnt_q   <= 32'h0;
				end
				// Discharge interval, then next unpowered port
				S_GAP:
				begin
					if (cnt_q >= gap_q && !pen_q[nxt_port])
					begin
						port_q  <= nxt_port;
						state_q <= S_DET1;
						cnt_q   <= 32'h0;
					end
				end
				S_DET1, S_DET2:
				begin
					if (det_finish)
					begin
						cnt_q   <= 32'h0;
						state_q <= (det_code == DET_VALID) ? S_CLS1 : S_GAP;
						gap_q   <= mid_q[port_q] ? RESET_CYC + MID_CYC : RESET_CYC;
					end
					else if (state_q == S_DET1 && phase_end)
					begin
						state_q <= S_DET2;
						cnt_q   <= 32'h0;
					end
				end
				S_CLS1, S_CLS2:
				begin
					if (class_done_i)
					begin
						cnt_q  <= 32'h0;
						cls1_q <= cls_now;
						if (cls_fin)
							state_q <= !cls_ok ? S_GAP : (state_q == S_CLS2 ? S_MARK2 : S_RAMP);
						else
							state_q <= S_MARK1;
						gap_q  <= RESET_CYC;
					end
				end
				// Mark events around the second class event
				S_MARK1, S_MARK2:
				begin
					if (cnt_q >= MARK_CYC - 1)
					begin
						state_q <= state_q == S_MARK1 ? S_CLS2 : S_RAMP;
						cnt_q   <= 32'h0;
					end
				end
				S_RAMP:
				begin
					if (ramp_done_i[port_q] || port_off_i[port_q])
					begin
						state_q <= S_GAP;
						gap_q   <= RESET_CYC;
						cnt_q   <= 32'h0;
					end
				end
			endcase
			// Valid detect not started in time redetects
			if (auto_q && wd_q >= START_CYC - 1 && state_q != S_GAP && state_q != S_DET1
				&& state_q != S_DET2 && state_q != S_START && state_q != S_OVP)
			begin
				state_q <= S_DET1;
				cnt_q   <= 32'h0;
			end
		end
	end

	// Start-up watchdog, runs from valid detection until power
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			wd_q <= 32'h0;
		else if (state_q == S_DET2 || state_q == S_DET1 || state_q == S_GAP || clr)
			wd_q <= 32'h0;
		else
			wd_q <= wd_q + 32'h1;
	end

	// ********************************
	// Results and flags
	// ********************************
	// Store results, raise done flags; set beats clear
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			det_done_q <= 4'h0;
			cls_done_q <= 4'h0;
			det_res_q  <= '{default: 3'h0};
			cls_res_q  <= '{default: 3'h0};
		end
		else if (clr)
		begin
			det_done_q <= 4'h0;
			cls_done_q <= 4'h0;
			det_res_q  <= '{default: 3'h0};
			cls_res_q  <= '{default: 3'h0};
		end
		else
		begin
			if (wr_i && addr_i == OFS_EVENT)
			begin
				det_done_q <= (det_done_q & ~wdata_i[3:0]) | (det_finish ? sel : 4'h0);
				cls_done_q <= (cls_done_q & ~wdata_i[7:4]) | (cls_fin ? sel : 4'h0);
			end
			else
			begin
				det_done_q <= det_done_q | (det_finish ? sel : 4'h0);
				cls_done_q <= cls_done_q | (cls_fin ? sel : 4'h0);
			end
			if (det_finish)
				det_res_q[port_q] <= det_code;
			if (cls_fin)
				cls_res_q[port_q] <= cls_ok ? cls_now : CLS_FAIL;
		end
	end

	// Power enable, dropped on shutdown or over-voltage
	assign pen_set = (state_q == S_RAMP && !vin_ovp_i) ? (sel & ramp_done_i & ~port_off_i) : 4'h0;
	assign pen_clr = vin_ovp_i ? 4'hF : port_off_i;
	// Good level after this edge, change flags compare against it
	assign pg_d    = out_below_2v_i & ((pen_q & ~pen_clr) | pen_set);

	// Power status and change flags
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pen_q <= 4'h0;
			pec_q <= 4'h0;
			pg_q  <= 4'h0;
			pgc_q <= 4'h0;
		end
		else if (clr)
		begin
			pen_q <= 4'h0;
			pec_q <= 4'h0;
			pg_q  <= 4'h0;
			pgc_q <= 4'h0;
		end
		else
		begin
			pen_q <= (pen_q & ~pen_clr) | pen_set;
			// Good flag follows the two volt monitor
			pg_q  <= pg_d;
			if (wr_i && addr_i == OFS_PWRCHG)
			begin
				pec_q <= (pec_q & ~wdata_i[3:0]) | pen_set | (pen_q & pen_clr);
				pgc_q <= (pgc_q & ~wdata_i[7:4]) | (pg_q ^ pg_d);
			end
			else
			begin
				pec_q <= pec_q | pen_set | (pen_q & pen_clr);
				pgc_q <= pgc_q | (pg_q ^ pg_d);
			end
		end
	end

	// ********************************
	// Register read and outputs
	// ********************************
	always_comb
	begin
		rd_mux = RST_BYTE;
		unique case (addr_i)
			OFS_CTRL:   rd_mux = {6'h00, auto_q, 1'b1};
			OFS_MID:    rd_mux = {4'h0, mid_q};
			OFS_CLSCFG: rd_mux = {dual_en_q, hpc_en_q};
			OFS_EVENT:  rd_mux = {cls_done_q, det_done_q};
			OFS_PWR:    rd_mux = {pg_q, pen_q};
			OFS_PWRCHG: rd_mux = {pgc_q, pec_q};
			4'h6, 4'h7, 4'h8, 4'h9:
				rd_mux = {1'b0, cls_res_q[addr_i[1:0] - 2'h2], 1'b0, det_res_q[addr_i[1:0] - 2'h2]};
			OFS_STRAP:  rd_mux = {bus_id_q, pbud_q, hpc_strap_q, mid_strap_q, auto_q};
			OFS_STATE:  rd_mux = {2'h0, port_q, state_q};
			default:    rd_mux = RST_BYTE;
		endcase
	end

	// Read data and drive lines, all from flip-flops
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rdata_o      <= RST_BYTE;
			port_sel_o   <= 2'h0;
			probe_en_o   <= 1'b0;
			probe_high_o <= 1'b0;
			class_en_o   <= 1'b0;
			mark_en_o    <= 1'b0;
			gate_o       <= 4'h0;
			irq_o        <= 1'b0;
		end
		else
		begin
			rdata_o      <= rd_i ? rd_mux : RST_BYTE;
			port_sel_o   <= port_q;
			probe_en_o   <= state_q == S_DET1 || state_q == S_DET2;
			probe_high_o <= state_q == S_DET2;
			class_en_o   <= (state_q == S_CLS1 || state_q == S_CLS2) && !pen_q[port_q];
			mark_en_o    <= state_q == S_MARK1 || state_q == S_MARK2;
			gate_o       <= (state_q == S_RAMP && !vin_ovp_i && !clr) ? (pen_q | sel) & ~pen_clr
				: (clr ? 4'h0 : pen_q & ~pen_clr);
			irq_o        <= |{det_done_q, cls_done_q};
		end
	end

	// ********************************
	// Assertions
	// ********************************
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	a_soft_reset: assert property (clr |=> state_q == S_START && pen_q == 4'h0)
		else $error("reset request did not clear sequencer");
	a_strap_hold: assert property (!strap_load_q && !clr |=> $stable(auto_q))
		else $error("strap latch changed after capture");
	a_ovp_off: assert property (vin_ovp_i |=> pen_q == 4'h0 ##1 gate_o == 4'h0)
		else $error("ports still on during over-voltage");
	a_probe_gate: assert property (probe_en_o |-> (gate_o & (4'h1 << port_sel_o)) == 4'h0)
		else $error("pass transistor on while probing");
	a_det_flag: assert property (det_finish && !clr && !vin_ovp_i |=> det_done_q[$past(port_q)])
		else $error("detect done flag not set");
	a_lowz_end: assert property (state_q == S_DET2 && det_lowz_i && !clr && !vin_ovp_i
		|=> state_q == S_GAP)
		else $error("low impedance did not end detection");
	a_two_phase: assert property (state_q == S_DET1 && !det_finish && phase_end && !clr
		&& !vin_ovp_i |=> state_q == S_DET2)
		else $error("second phase skipped");
	a_hp_fail: assert property (state_q == S_CLS1 && class_done_i && class_over_i && !hp_en
		&& !clr && !vin_ovp_i && wd_q < START_CYC - 1 |=> state_q == S_GAP)
		else $error("over-limit class not failed");
	a_dual_match: assert property (state_q == S_CLS2 && class_done_i && cls_now != cls1_q
		&& !clr && !vin_ovp_i && wd_q < START_CYC - 1 |=> cls_res_q[$past(port_q)] == CLS_FAIL)
		else $error("mismatched second class accepted");
	a_pen_flags: assert property (pen_set != 4'h0 && !clr
		|=> (pen_q & pec_q & $past(pen_set)) == $past(pen_set))
		else $error("power enable flags missing");

	c_valid_det: cover property (det_finish && det_code == DET_VALID);
	c_dual_class: cover property (state_q == S_MARK2);
	c_powered: cover property (pen_set != 4'h0);

endmodule
`default_nettype wire

// ---- verification/pd_model.sv ----
// Purpose: Powered device and analog front end as seen by the sequencer
// Assumes: Bench sets each port's signature, class codes and answer delay
// Notes:   Class lines toggle outside the done pulse so stale codes show
`timescale 1ns/100ps
`default_nettype none
module pd_model
	import poe_seq_pkg::*;
(
	// Clock
	input  wire logic       core_clk_i,
	// Sequencer drive
	input  wire logic [1:0] port_sel_i,
	input  wire logic       probe_en_i,
	input  wire logic       probe_high_i,
	input  wire logic       class_en_i,
	input  wire logic [3:0] gate_i,
	// Front end verdicts
	output logic            det_open_o,
	output logic            det_short_o,
	output logic            det_cap_o,
	output logic            det_lowz_o,
	output logic            det_good_o,
	output logic            class_done_o,
	output logic      [2:0] class_code_o,
	output logic            class_over_o,
	output logic      [3:0] ramp_done_o
);
	// Kind: 0 open, 1 good, 2 low impedance, 3 other, 4 short, 5 capacitance
	logic [2:0] sig [4];
	logic [2:0] cls1 [4];     // First class answer
	logic [2:0] cls2 [4];     // Second class answer
	logic [3:0] over;         // Current above limit
	logic [7:0] dly = 8'h04;  // Class answer delay
	logic [2:0] kind;
	logic       ce_q = 1'b0;
	logic [7:0] cnt_q = 8'h00;
	logic       second_q = 1'b0;

	// Verdicts follow the probe on the selected port
	assign kind        = sig[port_sel_i];
	assign det_open_o  = probe_en_i && kind == 3'h0;
	assign det_good_o  = probe_en_i && probe_high_i && kind == 3'h1;
	assign det_lowz_o  = probe_en_i && kind == 3'h2;
	assign det_short_o = probe_en_i && kind == 3'h4;
	assign det_cap_o   = probe_en_i && kind == 3'h5;

	// Class answer a set delay after each rise of class voltage
	always @(posedge core_clk_i)
	begin
		ce_q <= class_en_i;
		ramp_done_o <= gate_i;
		class_done_o <= 1'b0;
		class_code_o <= ~class_code_o;
		class_over_o <= ~class_over_o;
		if (probe_en_i)
			second_q <= 1'b0;
		if (class_en_i && !ce_q)
			cnt_q <= dly;
		else if (cnt_q != 8'h00)
		begin
			cnt_q <= cnt_q - 8'h01;
			if (cnt_q == 8'h01)
			begin
				class_done_o <= 1'b1;
				class_code_o <= second_q ? cls2[port_sel_i] : cls1[port_sel_i];
				class_over_o <= over[port_sel_i];
				second_q <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ---- verification/poe_port_sequencer_test.sv ----
// Purpose: Register and sequencing checks of the four-port sequencer
// Assumes: Shortened waits, front end model on the port side
// Notes:   Result reads follow each completion closely
`timescale 1ns/100ps
`default_nettype none
module poe_port_sequencer_test;
	import poe_seq_pkg::*;
	logic       core_clk_i = 1'b0;
	logic       rst_n_i = 1'b0;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00;
	logic       wr_i = 1'b0;
	logic       rd_i = 1'b0;
	logic       en_i = 1'b1;
	logic       vin_uvlo_i = 1'b0;
	logic       vin_ovp_i = 1'b0;
	logic       auto_strap_i = 1'b1;
	logic       midspan_strap_i = 1'b0;
	logic       high_power_class_strap_i = 1'b0;
	logic       power_budget_strap_i = 1'b1;
	logic [3:0] bus_id_straps_i = 4'hA;
	logic [3:0] out_below_2v_i = 4'hF;
	logic [3:0] port_off_i = 4'h0;
	logic [7:0] rdata_o;
	logic       det_open_i, det_short_i, det_cap_i, det_lowz_i, det_good_i;
	logic       class_done_i, class_over_i, probe_en_o, probe_high_o;
	logic       class_en_o, mark_en_o, irq_o;
	logic [2:0] class_code_i;
	logic [3:0] ramp_done_i, gate_o;
	logic [1:0] port_sel_o;
	int         err_total = 0;
	int         comparisons = 0;
	logic [7:0] hi_seen = 8'h00;                 // Ports that reached phase two
	logic       mark_seen = 1'b0;
	logic       hi_clr = 1'b0;                   // Restart phase two record
	logic       pe_q = 1'b0;
	logic [1:0] ord [6];                         // Ports in order of service
	int         n_ord = 0;
	logic [7:0] d;
	logic [7:0] exp_ord [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h00, 8'h02};

	poe_port_sequencer #(.RESET_CYC(20), .MID_CYC(50), .START_CYC(3000)) poe_port_sequencer_i (
		.core_clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.vin_uvlo_i, .vcc_uvlo_i(1'b0), .en_i, .vin_ovp_i, .auto_strap_i,
		.midspan_strap_i, .high_power_class_strap_i, .power_budget_strap_i,
		.bus_id_straps_i, .det_open_i, .det_short_i, .det_cap_i, .det_lowz_i,
		.det_good_i, .class_done_i, .class_code_i, .class_over_i, .ramp_done_i,
		.out_below_2v_i, .port_off_i, .port_sel_o, .probe_en_o,
		.probe_high_o, .class_en_o, .mark_en_o, .gate_o, .irq_o);

	pd_model pd_model_i (.core_clk_i, .port_sel_i(port_sel_o), .probe_en_i(probe_en_o),
		.probe_high_i(probe_high_o), .class_en_i(class_en_o), .gate_i(gate_o),
		.det_open_o(det_open_i), .det_short_o(det_short_i), .det_cap_o(det_cap_i),
		.det_lowz_o(det_lowz_i), .det_good_o(det_good_i), .class_done_o(class_done_i),
		.class_code_o(class_code_i), .class_over_o(class_over_i), .ramp_done_o(ramp_done_i));

	initial
		forever #50 core_clk_i = ~core_clk_i;

	// Record service order, second probe phase and mark drive
	always @(posedge core_clk_i)
	begin
		pe_q <= probe_en_o;
		if (probe_en_o && !pe_q && n_ord < 6)
		begin
			ord[n_ord] <= port_sel_o;
			n_ord <= n_ord + 1;
		end
		if (hi_clr)
			hi_seen <= 8'h00;
		else if (probe_high_o)
			hi_seen[port_sel_o] <= 1'b1;
		if (mark_en_o)
			mark_seen <= 1'b1;
	end

	// ****************************************
	// Bus and check tasks
	// ****************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		comparisons++;
		if (seen !== want)
		begin
			err_total++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge core_clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge core_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		@(posedge core_clk_i);
		d = rdata_o;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [7:0] want);
		rd(a);
		check(d, want);
	endtask
	// Read until every bit of the mask is set, bounded
	task automatic poll(input logic [3:0] a, input logic [7:0] m);
		for (int i = 0; i < 8000 && (d & m) !== m; i++)
			rd(a);
		check(d & m, m);
		d = 8'h00;
	endtask
	task automatic cfg(input int p, input logic [2:0] s, a, b, input logic o);
		pd_model_i.sig[p] <= s;
		pd_model_i.cls1[p] <= a;
		pd_model_i.cls2[p] <= b;
		pd_model_i.over[p] <= o;
	endtask
	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial
	begin
		d = 8'h00;
		cfg(0, 3'h0, 3'h0, 3'h0, 1'b0);
		cfg(1, 3'h1, 3'h2, 3'h2, 1'b0);
		cfg(2, 3'h2, 3'h0, 3'h0, 1'b0);
		cfg(3, 3'h1, 3'h4, 3'h4, 1'b1);
		repeat (12) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		rdc(OFS_CTRL, 8'h03);
		rdc(OFS_STRAP, 8'hA9);
		midspan_strap_i <= 1'b1;
		high_power_class_strap_i <= 1'b1;
		power_budget_strap_i <= 1'b0;
		bus_id_straps_i <= 4'h5;
		auto_strap_i <= 1'b0;
		rdc(OFS_STRAP, 8'hA9);
		rdc(4'hF, 8'h00);
		wr(OFS_PWR, 8'hFF);
		rdc(OFS_PWR, 8'h00);
		wr(OFS_MID, 8'h0E);
		rdc(OFS_MID, 8'h0E);
		poll(OFS_EVENT, 8'hAF);
		check({7'h00, irq_o}, 8'h01);
		rdc(OFS_RES0, 8'h05);
		rdc(OFS_RES0 + 4'h1, 8'h24);
		rdc(OFS_RES0 + 4'h2, 8'h03);
		rdc(OFS_RES0 + 4'h3, 8'h74);
		poll(OFS_PWR, 8'h22);
		rdc(OFS_PWRCHG, 8'h22);
		wr(OFS_PWRCHG, 8'h22);
		rdc(OFS_PWRCHG, 8'h00);
		rdc(OFS_MID, 8'h04);
		for (int i = 0; i < 20000 && n_ord < 6; i++)
			@(posedge core_clk_i);
		for (int i = 0; i < 6; i++)
			check({6'h00, ord[i]}, exp_ord[i]);
		check(hi_seen, 8'h0A);
		// Short, capacitance and other invalid signatures
		wr(OFS_EVENT, 8'hFF);
		cfg(0, 3'h4, 3'h0, 3'h0, 1'b0);
		cfg(2, 3'h5, 3'h0, 3'h0, 1'b0);
		cfg(3, 3'h3, 3'h0, 3'h0, 1'b0);
		hi_clr <= 1'b1;
		@(posedge core_clk_i);
		hi_clr <= 1'b0;
		poll(OFS_EVENT, 8'h0D);
		rdc(OFS_RES0, 8'h01);
		rdc(OFS_RES0 + 4'h2, 8'h02);
		rdc(OFS_RES0 + 4'h3, 8'h76);
		check(hi_seen, 8'h08);
		// Over-voltage drops every port, then detection restarts
		vin_ovp_i <= 1'b1;
		wr(OFS_EVENT, 8'hFF);
		check({4'h0, gate_o}, 8'h00);
		vin_ovp_i <= 1'b0;
		poll(OFS_EVENT, 8'h01);
		poll(OFS_PWR, 8'h02);
		// Software reset with new straps, dual event and slow answers
		cfg(0, 3'h1, 3'h4, 3'h4, 1'b0);
		cfg(1, 3'h1, 3'h4, 3'h3, 1'b0);
		cfg(2, 3'h1, 3'h4, 3'h4, 1'b1);
		pd_model_i.dly <= 8'h28;
		wr(OFS_CTRL, 8'h00);
		wr(OFS_CLSCFG, 8'h30);
		check({4'h0, gate_o}, 8'h00);
		rdc(OFS_STRAP, 8'h56);
		rdc(OFS_EVENT, 8'h00);
		rdc(OFS_MID, 8'h0F);
		poll(OFS_EVENT, 8'h7F);
		rdc(OFS_RES0 + 4'h1, 8'h74);
		rdc(OFS_RES0, 8'h44);
		rdc(OFS_RES0 + 4'h2, 8'h54);
		check({7'h00, mark_seen}, 8'h01);
		poll(OFS_PWR, 8'h05);
		rdc(OFS_MID, 8'h08);
		// Shutdown of port one drops its power
		port_off_i <= 4'h1;
		@(posedge core_clk_i);
		port_off_i <= 4'h0;
		rdc(OFS_PWR, 8'h44);
		// Enable pin low resets the device
		en_i <= 1'b0;
		@(posedge core_clk_i);
		en_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		rdc(OFS_PWR, 8'h00);
		check({7'h00, irq_o}, 8'h00);
		// Undervoltage resets and reloads midspan from strap
		wr(OFS_MID, 8'h00);
		vin_uvlo_i <= 1'b1;
		@(posedge core_clk_i);
		vin_uvlo_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		rdc(OFS_MID, 8'h0F);
		complete_run();
	end

	// Watchdog well beyond the expected run
	initial
	begin
		repeat (95000) @(posedge core_clk_i);
		err_total++;
		complete_run();
	end
endmodule
`default_nettype wire
